// File: core/pll_serial_pkg.sv
// package: field layout, select codes and constants of the serial register bank
package pll_serial_pkg;
   // word and select field
   localparam int WORD_W = 32;
   localparam int SEL_W = 3;
   localparam logic [2:0] SEL_INT_FRACTION_NUMERATOR = 3'h0;
   localparam logic [2:0] SEL_PHASE_MOD = 3'h1;
   localparam logic [2:0] SEL_REF_MODE = 3'h2;
   localparam logic [2:0] SEL_CLKDIV = 3'h3;
   localparam logic [2:0] SEL_FIXED = 3'h4;
   localparam logic [2:0] SEL_LOCKPIN = 3'h5;
   // register 0 fields
   localparam int INT_LSB = 15;
   localparam int INT_W = 16;
   localparam int FRACTION_NUMERATOR_LSB = 3;
   localparam int FRACTION_NUMERATOR_W = 12;
   // register 1 fields
   localparam int PHADJ_BIT = 28;
   localparam int PRESC_BIT = 27;
   localparam int PHASE_LSB = 15;
   localparam int PHASE_W = 12;
   localparam int MOD_LSB = 3;
   localparam int MOD_W = 12;
   // register 2 fields
   localparam int NOISE_LSB = 29;
   localparam int NOISE_W = 2;
   localparam int MUX_LSB = 26;
   localparam int MUX_W = 3;
   localparam int DBL_BIT = 25;
   localparam int HALF_BIT = 24;
   localparam int RCNT_LSB = 14;
   localparam int RCNT_W = 10;
   localparam int CP_LSB = 9;
   localparam int CP_W = 4;
   localparam int LDF_BIT = 8;
   localparam int LDP_BIT = 7;
   localparam int PDPOL_BIT = 6;
   localparam int PD_BIT = 5;
   localparam int CPTRI_BIT = 4;
   localparam int CRST_BIT = 3;
   // register 3 fields
   localparam int ABP_BIT = 22;
   localparam int CHGCAN_BIT = 21;
   localparam int CSR_BIT = 18;
   localparam int CLKMODE_LSB = 15;
   localparam int CLKMODE_W = 2;
   localparam int CLKDIV_LSB = 3;
   localparam int CLKDIV_W = 12;
   // register 5 fields
   localparam int LDPIN_LSB = 22;
   localparam int LDPIN_W = 2;

   // settings that take effect only with the next register 0 write
   typedef struct packed {
      logic [PHASE_W-1:0] phase_word;
      logic [MOD_W-1:0] fraction_modulus;
      logic reference_doubler;
      logic reference_halving;
      logic [RCNT_W-1:0] reference_count;
      logic [CP_W-1:0] pump_current;
   } double_buffered_field_s;

   // settings that act as soon as their word is latched
   typedef struct packed {
      logic phase_adjust_enable;
      logic prescaler_select;
      logic [NOISE_W-1:0] noise_mode;
      logic [MUX_W-1:0] monitor_output_select;
      logic lock_detect_function;
      logic lock_detect_precision;
      logic detector_polarity;
      logic power_down;
      logic pump_three_state;
      logic counter_reset;
      logic antibacklash_width;
      logic charge_cancel;
      logic cycle_slip_reduction;
      logic [CLKMODE_W-1:0] clock_div_mode;
      logic [CLKDIV_W-1:0] clock_div_value;
      logic [LDPIN_W-1:0] lock_pin_mode;
   } direct_field_s;
endpackage

// File: core/pll_serial_register_bank.sv
// serial loaded configuration register bank with double buffered settings
`timescale 1ns/1ps
`default_nettype none

module pll_serial_register_bank (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // serial link pins
   input wire logic serial_clock_i,
   input wire logic serial_data_i,
   input wire logic latch_strobe_i,
   // divider and control settings toward the synthesizer core
   output logic [pll_serial_pkg::INT_W-1:0] integer_value_o,
   output logic [pll_serial_pkg::FRACTION_NUMERATOR_W-1:0] fraction_numerator_o,
   output pll_serial_pkg::double_buffered_field_s active_buffered_o,
   output pll_serial_pkg::direct_field_s direct_fields_o,
   // events toward the synthesizer core
   output logic divider_update_o,
   output logic phase_resync_o
);

   // synchronisers: the first stage is read by the second stage only
   logic [2:0] sync_a;
   logic [2:0] sync_b;

   // previous synchronised levels for edge detection
   logic sclk_prev;
   logic strobe_prev;

   // input shift register and the first buffer stage
   logic [pll_serial_pkg::WORD_W-1:0] shift_word;
   pll_serial_pkg::double_buffered_field_s pending_buffered;

   // decoded select, edges and latch events
   logic [pll_serial_pkg::SEL_W-1:0] sel;
   logic sclk_rise;
   logic strobe_rise;
   logic divider_latch;
   logic resync_enabled;

   // two flops per pin: the pins are asynchronous to the system clock, so a
   // link clock half period shorter than one system clock may be missed
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end
      else
      begin
         sync_a <= {latch_strobe_i, serial_data_i, serial_clock_i};
         sync_b <= sync_a;
      end
   end

   // edge history on the synchronised levels
   // reset to the idle low level of the pins, so no false edge follows reset
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         sclk_prev <= 1'b0;
         strobe_prev <= 1'b0;
      end
      else
      begin
         sclk_prev <= sync_b[0];
         strobe_prev <= sync_b[2];
      end
   end

   // rising edges of the synchronised pins, and the select field of the word
   assign sclk_rise = sync_b[0] & ~sclk_prev;
   assign strobe_rise = sync_b[2] & ~strobe_prev;
   assign sel = shift_word[pll_serial_pkg::SEL_W-1:0];
   // register 0 latch, and the resync mode chosen by registers 1 and 3
   assign divider_latch = strobe_rise && sel == pll_serial_pkg::SEL_INT_FRACTION_NUMERATOR;
   assign resync_enabled = !direct_fields_o.phase_adjust_enable
      && direct_fields_o.clock_div_mode != 2'h0;

   // data and clock pass the same synchroniser depth, so data is stable at the edge
   // a frame longer than 32 bits keeps only its last 32
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         shift_word <= 32'h0000_0000;
      else if (sclk_rise)
         shift_word <= {shift_word[pll_serial_pkg::WORD_W-2:0], sync_b[1]};
   end

   // register 0: integer and fraction, applied immediately
   // no range check here: the host keeps the integer legal for its prescaler
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         integer_value_o <= 16'h0000;
         fraction_numerator_o <= 12'h000;
      end
      else if (strobe_rise && sel == pll_serial_pkg::SEL_INT_FRACTION_NUMERATOR)
      begin
         // upper bit 31 is reserved and ignored
         integer_value_o <= shift_word[pll_serial_pkg::INT_LSB +: pll_serial_pkg::INT_W];
         fraction_numerator_o <= shift_word[pll_serial_pkg::FRACTION_NUMERATOR_LSB +: pll_serial_pkg::FRACTION_NUMERATOR_W];
      end
   end

   // first stage of the double buffer: registers 1 and 2 fill the pending copy
   // registers 1 and 2 may come in either order before the register 0 write
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         pending_buffered <= '0;
      else if (strobe_rise && sel == pll_serial_pkg::SEL_PHASE_MOD)
      begin
         pending_buffered.phase_word <=
            shift_word[pll_serial_pkg::PHASE_LSB +: pll_serial_pkg::PHASE_W];
         pending_buffered.fraction_modulus <=
            shift_word[pll_serial_pkg::MOD_LSB +: pll_serial_pkg::MOD_W];
      end
      else if (strobe_rise && sel == pll_serial_pkg::SEL_REF_MODE)
      begin
         pending_buffered.reference_doubler <= shift_word[pll_serial_pkg::DBL_BIT];
         pending_buffered.reference_halving <= shift_word[pll_serial_pkg::HALF_BIT];
         // full 10-bit count kept; ratio 1..1023 is used as written
         pending_buffered.reference_count <=
            shift_word[pll_serial_pkg::RCNT_LSB +: pll_serial_pkg::RCNT_W];
         pending_buffered.pump_current <=
            shift_word[pll_serial_pkg::CP_LSB +: pll_serial_pkg::CP_W];
      end
   end

   // second stage: the pending copy goes live only with a register 0 write
   // a register 0 write with no new register 1 or 2 word reloads the same copy
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         active_buffered_o <= '0;
      else if (strobe_rise && sel == pll_serial_pkg::SEL_INT_FRACTION_NUMERATOR)
         active_buffered_o <= pending_buffered;
   end

   // fields that act as soon as their word is latched
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         direct_fields_o <= '0;
      else if (strobe_rise)
      begin
         case (sel)
            pll_serial_pkg::SEL_PHASE_MOD:
            begin
               direct_fields_o.phase_adjust_enable <= shift_word[pll_serial_pkg::PHADJ_BIT];
               direct_fields_o.prescaler_select <= shift_word[pll_serial_pkg::PRESC_BIT];
            end
            pll_serial_pkg::SEL_REF_MODE:
            begin
               direct_fields_o.noise_mode <=
                  shift_word[pll_serial_pkg::NOISE_LSB +: pll_serial_pkg::NOISE_W];
               direct_fields_o.monitor_output_select <=
                  shift_word[pll_serial_pkg::MUX_LSB +: pll_serial_pkg::MUX_W];
               direct_fields_o.lock_detect_function <= shift_word[pll_serial_pkg::LDF_BIT];
               direct_fields_o.lock_detect_precision <= shift_word[pll_serial_pkg::LDP_BIT];
               direct_fields_o.detector_polarity <= shift_word[pll_serial_pkg::PDPOL_BIT];
               direct_fields_o.power_down <= shift_word[pll_serial_pkg::PD_BIT];
               direct_fields_o.pump_three_state <= shift_word[pll_serial_pkg::CPTRI_BIT];
               direct_fields_o.counter_reset <= shift_word[pll_serial_pkg::CRST_BIT];
            end
            pll_serial_pkg::SEL_CLKDIV:
            begin
               direct_fields_o.antibacklash_width <= shift_word[pll_serial_pkg::ABP_BIT];
               direct_fields_o.charge_cancel <= shift_word[pll_serial_pkg::CHGCAN_BIT];
               direct_fields_o.cycle_slip_reduction <= shift_word[pll_serial_pkg::CSR_BIT];
               direct_fields_o.clock_div_mode <=
                  shift_word[pll_serial_pkg::CLKMODE_LSB +: pll_serial_pkg::CLKMODE_W];
               direct_fields_o.clock_div_value <=
                  shift_word[pll_serial_pkg::CLKDIV_LSB +: pll_serial_pkg::CLKDIV_W];
            end
            pll_serial_pkg::SEL_LOCKPIN:
               direct_fields_o.lock_pin_mode <=
                  shift_word[pll_serial_pkg::LDPIN_LSB +: pll_serial_pkg::LDPIN_W];
            // register 4 holds only fixed bits; codes 6 and 7 latch nothing
            default:
               direct_fields_o <= direct_fields_o;
         endcase
      end
   end

   // one-cycle events for the core: divider reload and optional phase resync
   // registered, so the pulses line up with the new divider settings
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         divider_update_o <= 1'b0;
         phase_resync_o <= 1'b0;
      end
      else
      begin
         divider_update_o <= divider_latch;
         // resync only when phase adjust is off and resync mode is chosen
         phase_resync_o <= divider_latch && resync_enabled;
      end
   end

endmodule
`default_nettype wire

// File: test/pll_serial_register_bank_asserts.sv
// checker for the serial register bank outputs
`timescale 1ns/1ps
`default_nettype none
module pll_serial_register_bank_asserts (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // latch pin
   input wire logic latch_strobe_i,
   // settings and events
   input wire logic [pll_serial_pkg::INT_W-1:0] integer_value_o,
   input wire logic [pll_serial_pkg::FRACTION_NUMERATOR_W-1:0] fraction_numerator_o,
   input wire pll_serial_pkg::double_buffered_field_s active_buffered_o,
   input wire pll_serial_pkg::direct_field_s direct_fields_o,
   input wire logic divider_update_o,
   input wire logic phase_resync_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   property p_pulse; divider_update_o |=> !divider_update_o; endproperty
   a_pulse: assert property (p_pulse) else $error("long update");
   property p_cause; divider_update_o |-> $past(latch_strobe_i, 2); endproperty
   a_cause: assert property (p_cause) else $error("update without strobe");
   // strobe seen low three times rules out an answer next cycle
   property p_quiet; !latch_strobe_i [*3] |=> !divider_update_o; endproperty
   a_quiet: assert property (p_quiet) else $error("early update");
   property p_dir;
      $changed(direct_fields_o) |-> $past(latch_strobe_i, 2) && !divider_update_o;
   endproperty
   a_dir: assert property (p_dir) else $error("direct change");
   property p_int; $changed(integer_value_o) |-> divider_update_o; endproperty
   a_int: assert property (p_int) else $error("integer change");
   property p_fraction_numerator; $changed(fraction_numerator_o) |-> divider_update_o; endproperty
   a_fraction_numerator: assert property (p_fraction_numerator) else $error("fraction change");
   property p_buf; $changed(active_buffered_o) |-> divider_update_o; endproperty
   a_buf: assert property (p_buf) else $error("buffered change");
   property p_rsy;
      phase_resync_o == (divider_update_o && !direct_fields_o.phase_adjust_enable
         && direct_fields_o.clock_div_mode != 2'h0);
   endproperty
   a_rsy: assert property (p_rsy) else $error("resync wrong");
endmodule
bind pll_serial_register_bank pll_serial_register_bank_asserts i_asserts (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .latch_strobe_i(latch_strobe_i),
   .integer_value_o(integer_value_o), .fraction_numerator_o(fraction_numerator_o),
   .active_buffered_o(active_buffered_o), .direct_fields_o(direct_fields_o),
   .divider_update_o(divider_update_o), .phase_resync_o(phase_resync_o));
`default_nettype wire

// File: test/host_serial_model.sv
// host model driving the three wire link
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   // clock
   input wire logic sys_clk_i,
   // link pins
   output logic serial_clock_o,
   output logic serial_data_o,
   output logic latch_strobe_o
);
   // link clock stands low between frames
   initial
   begin
      serial_clock_o = 1'b0;
      serial_data_o = 1'b0;
      latch_strobe_o = 1'b0;
   end
   // four system clocks per half period gives the 800 ns link clock
   task automatic send_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         serial_data_o <= w[i]; // msb first, changed with the falling link clock
         repeat (4) @(posedge sys_clk_i);
         serial_clock_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         serial_clock_o <= 1'b0;
      end
      repeat (4) @(posedge sys_clk_i);
      latch_strobe_o <= 1'b1;
      serial_data_o <= ~w[0]; // stale data must not be relied on
      repeat (8) @(posedge sys_clk_i);
      latch_strobe_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
   endtask
endmodule
`default_nettype wire

// File: test/pll_serial_register_bank_bench.sv
// self-checking bench for the serial register bank
`timescale 1ns/1ps
`default_nettype none
module pll_serial_register_bank_bench;
   logic sys_clk, rst, sclk, sdat, strobe, upd, rsy;
   logic [15:0] int_v;
   logic [11:0] fraction_numerator_v;
   pll_serial_pkg::double_buffered_field_s buf_v;
   pll_serial_pkg::direct_field_s dir_v;
   int n_errors = 0;
   int check_count = 0;
   int n_upd = 0;
   int n_rsy = 0;
   pll_serial_register_bank i_pll_serial_register_bank (.sys_clk_i(sys_clk), .rst_i(rst),
      .serial_clock_i(sclk), .serial_data_i(sdat), .latch_strobe_i(strobe),
      .integer_value_o(int_v), .fraction_numerator_o(fraction_numerator_v), .active_buffered_o(buf_v),
      .direct_fields_o(dir_v), .divider_update_o(upd), .phase_resync_o(rsy));
   host_serial_model i_host_serial_model (.sys_clk_i(sys_clk), .serial_clock_o(sclk),
      .serial_data_o(sdat), .latch_strobe_o(strobe));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // pulses stand one cycle, so count them every cycle
   always @(posedge sys_clk)
   begin
      if (upd === 1'b1) n_upd++;
      if (rsy === 1'b1) n_rsy++;
   end
   task automatic chk(input string what, input logic [39:0] e, input logic [39:0] g);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask
   task automatic put(input logic [31:0] w);
      i_host_serial_model.send_word(w);
   endtask
   task automatic t_buffer();
      put({3'h0, 2'b01, 12'hABC, 12'hFFF, 3'h1});
      put({1'b0, 2'h3, 3'h5, 2'b11, 10'h3FF, 1'b0, 4'hA, 6'h2A, 3'h2});
      chk("held", 40'h0, buf_v);
      chk("prescaler", 40'h1, dir_v.prescaler_select);
      chk("mux", 40'h5, dir_v.monitor_output_select);
      put({1'b0, 16'h1000, 12'h001, 3'h0});
      chk("buffered", {12'hABC, 12'hFFF, 2'b11, 10'h3FF, 4'hA}, buf_v);
      $display("buffer test done");
   endtask
   task automatic t_int_fraction_numerator();
      int u;
      u = n_upd;
      put({1'b0, 16'hFFFF, 12'hFFE, 3'h0});
      chk("integer", 40'hFFFF, int_v);
      chk("fraction", 40'hFFE, fraction_numerator_v);
      put({1'b0, 16'h004B, 12'h000, 3'h0});
      chk("integer", 40'h4B, int_v);
      chk("updates", 40'h2, n_upd - u);
      put({3'h0, 2'h0, 12'hABC, 12'hFFF, 3'h1});
      chk("prescaler", 40'h0, dir_v.prescaler_select);
      put({1'b0, 16'h0017, 12'h000, 3'h0});
      chk("integer", 40'h17, int_v);
      put({1'b0, 16'h7FFF, 12'h000, 3'h0});
      chk("integer", 40'h7FFF, int_v);
      $display("integer test done");
   endtask
   task automatic t_resync();
      int r;
      put({9'h0, 6'h22, 2'h1, 12'h00C, 3'h3});
      chk("divider", 40'h00C, dir_v.clock_div_value);
      chk("direct", {2'h0, 2'h3, 3'h5, 6'h2A, 3'h5, 2'h1, 12'h00C, 2'h0}, dir_v);
      r = n_rsy;
      put({3'h0, 2'b11, 12'h001, 12'hFFF, 3'h1});
      put({1'b0, 16'h0100, 12'h000, 3'h0});
      chk("resync", r, n_rsy);
      put({3'h0, 2'b01, 12'h001, 12'hFFF, 3'h1});
      put({1'b0, 16'h0100, 12'h000, 3'h0});
      chk("resync", r + 1, n_rsy);
      $display("resync test done");
   endtask
   task automatic t_refused();
      logic [2:0] sel [3] = '{3'h4, 3'h6, 3'h7};
      int u;
      u = n_upd;
      foreach (sel[k]) put({8'h00, 1'b1, 20'h0, sel[k]});
      chk("integer", 40'h100, int_v);
      chk("updates", 40'h0, n_upd - u);
      put({8'h00, 2'h3, 19'h0, 3'h5});
      chk("lock pin", 40'h3, dir_v.lock_pin_mode);
      $display("select test done");
   endtask
   task automatic t_reset();
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk("integer", 40'h0, int_v);
      chk("fraction", 40'h0, fraction_numerator_v);
      chk("buffered", 40'h0, buf_v);
      chk("direct", 40'h0, dir_v);
      $display("reset test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      t_buffer();
      t_int_fraction_numerator();
      t_resync();
      t_refused();
      t_reset();
      end_of_test();
   end
endmodule
`default_nettype wire
